// ---- pc_stack_map.svh ----
// Offsets, field positions and reset values for the program counter block
`ifndef PC_STACK_MAP_SVH
`define PC_STACK_MAP_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define PCS_OFF_LOW          12'h000
`define PCS_OFF_LATCH        12'h004
`define PCS_OFF_STATE        12'h008

// ****************************************
// Field positions
// ****************************************
`define PCS_LOW_MSB          7
`define PCS_LATCH_MSB        4
`define PCS_PAGE_MSB         4
`define PCS_PAGE_LSB         3
`define PCS_FETCH_MSB        10
`define PCS_STATE_DEPTH_LSB  8

// ****************************************
// Widths, depths and reset values
// ****************************************
`define PCS_PC_WIDTH         13
`define PCS_STACK_DEPTH      8
`define PCS_PC_RESET         13'h0000
`define PCS_LATCH_RESET      5'h00
`define PCS_VECTOR_ADDR      13'h0004
`define PCS_PC_ONE           13'h0001

`endif

// ---- pc_stack_pkg.sv ----
// Types shared by the program counter and return stack
package pc_stack_pkg;

   typedef logic [12:0] pc_t;

   // Source of the next program counter value, highest priority first
   typedef enum logic [2:0] {
      SRC_VECTOR,
      SRC_BRANCH,
      SRC_RETURN,
      SRC_LOW_WRITE,
      SRC_STEP,
      SRC_HOLD
   } pc_src_e;

endpackage : pc_stack_pkg

// ---- pc_return_stack.sv ----
// Circular return-address stack held in flip-flops
`timescale 1ns/1ns
`include "pc_stack_map.svh"

module pc_return_stack #(
   parameter int WIDTH = `PCS_PC_WIDTH,
   parameter int DEPTH = `PCS_STACK_DEPTH
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] pop_data,
   output logic      [$clog2(DEPTH)-1:0] fill_ptr
);

   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
      $error("pc_return_stack: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] entry_reg [DEPTH];
   logic [PW-1:0]    ptr_reg;
   logic [PW-1:0]    ptr_next;
   wire  [PW-1:0]    top_idx = ptr_reg - {{(PW-1){1'b0}}, 1'b1};

   // Pointer wraps freely; no overflow or underflow flag exists
   assign ptr_next = push ? ptr_reg + {{(PW-1){1'b0}}, 1'b1}
                   : pop  ? top_idx
                   : ptr_reg;
   assign pop_data = entry_reg[top_idx];
   assign fill_ptr = ptr_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_reg <= '0;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   // Ninth push lands on the slot of the first
   always_ff @(posedge pclk) begin
      if (push) begin
         entry_reg[ptr_reg] <= push_data;
      end
   end

   a_wrap_pointer: assert property (@(posedge pclk) disable iff (!presetn)
      push |=> ptr_reg == $past(ptr_reg) + 1'b1)
      else $error("stack pointer did not advance on push");

   a_pushed_on_top: assert property (@(posedge pclk) disable iff (!presetn)
      push |=> pop_data == $past(push_data))
      else $error("pushed value not on top of stack");

endmodule : pc_return_stack

// ---- program_counter_and_stack.sv ----
// Program counter sequencing, high-address latch and return stack with APB access
`timescale 1ns/1ns
`include "pc_stack_map.svh"

module program_counter_and_stack #(
   parameter int                   STACK_DEPTH = `PCS_STACK_DEPTH,
   parameter logic [12:0]          VECTOR_ADDR = `PCS_VECTOR_ADDR
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Decoder and interrupt controls, one-cycle pulses
   input  wire logic               step,
   input  wire logic               branch_call,
   input  wire logic               branch_jump,
   input  wire logic [10:0]        branch_target,
   input  wire logic               return_plain,
   input  wire logic               return_with_literal,
   input  wire logic               interrupt_exit,
   input  wire logic               interrupt_take,
   // Program memory side
   output logic      [12:0]        pc_value,
   output logic      [10:0]        fetch_addr
);

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (STACK_DEPTH != `PCS_STACK_DEPTH) begin : g_depth_check
      $error("program_counter_and_stack: stack depth must be eight");
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic pc_stack_pkg::pc_t next_addr(input pc_stack_pkg::pc_t a);
      next_addr = a + `PCS_PC_ONE;
   endfunction : next_addr

   localparam int SPW = $clog2(STACK_DEPTH);

   // ****************************************
   // State
   // ****************************************
   pc_stack_pkg::pc_t    pc_reg;
   pc_stack_pkg::pc_t    pc_next;
   logic [4:0]           latch_reg;
   logic [4:0]           latch_next;
   logic [31:0]          prdata_reg;
   logic [31:0]          prdata_next;
   logic                 pslverr_reg;
   logic                 pslverr_next;

   // ****************************************
   // APB decode
   // ****************************************
   wire        apb_setup     = psel && !penable;
   wire        apb_access    = psel && penable;
   wire        hit_low       = paddr == `PCS_OFF_LOW;
   wire        hit_latch     = paddr == `PCS_OFF_LATCH;
   wire        hit_state     = paddr == `PCS_OFF_STATE;
   wire        hit_any       = hit_low || hit_latch || hit_state;
   wire        wr_low        = apb_access && pwrite && hit_low;
   wire        wr_latch      = apb_access && pwrite && hit_latch;
   wire        bad_access    = !hit_any || (pwrite && hit_state);

   // ****************************************
   // Stack controls
   // ****************************************
   wire        branch_any    = branch_call || branch_jump;
   wire        return_any    = return_plain || return_with_literal || interrupt_exit;
   wire        do_push       = interrupt_take || branch_call;
   wire        do_pop        = !interrupt_take && !branch_any && return_any;
   pc_stack_pkg::pc_t    push_value;
   pc_stack_pkg::pc_t    pop_value;
   logic [SPW-1:0]       stack_fill;

   // Interrupted instruction has not run yet, so it is the resume point
   assign push_value = interrupt_take ? pc_reg : next_addr(pc_reg);

   // ****************************************
   // Next program counter source
   // ****************************************
   pc_stack_pkg::pc_src_e pc_src;

   assign pc_src = interrupt_take ? pc_stack_pkg::SRC_VECTOR
                 : branch_any     ? pc_stack_pkg::SRC_BRANCH
                 : return_any     ? pc_stack_pkg::SRC_RETURN
                 : wr_low         ? pc_stack_pkg::SRC_LOW_WRITE
                 : step           ? pc_stack_pkg::SRC_STEP
                 : pc_stack_pkg::SRC_HOLD;

   always_comb begin
      case (pc_src)
         pc_stack_pkg::SRC_VECTOR: begin
            pc_next = VECTOR_ADDR;
         end
         pc_stack_pkg::SRC_BRANCH: begin
            pc_next = {latch_reg[`PCS_PAGE_MSB:`PCS_PAGE_LSB], branch_target};
         end
         pc_stack_pkg::SRC_RETURN: begin
            pc_next = pop_value;
         end
         pc_stack_pkg::SRC_LOW_WRITE: begin
            // Sum written by software does not carry into the upper bits
            pc_next = {latch_reg, pwdata[`PCS_LOW_MSB:0]};
         end
         pc_stack_pkg::SRC_STEP: begin
            pc_next = next_addr(pc_reg);
         end
         default: begin
            pc_next = pc_reg;
         end
      endcase
   end

   // Latch only moves on a software write, never on push or pop
   assign latch_next = wr_latch ? pwdata[`PCS_LATCH_MSB:0] : latch_reg;

   // ****************************************
   // Read data, captured in the setup phase
   // ****************************************
   // Upper counter bits are never returned; stack pointer never exposed
   wire [31:0] rd_low    = {24'h000000, pc_reg[`PCS_LOW_MSB:0]};
   wire [31:0] rd_latch  = {27'h0000000, latch_reg};
   wire [31:0] rd_state  = {23'h000000, interrupt_take,
                            8'h00};

   assign prdata_next  = !apb_setup ? prdata_reg
                       : pwrite     ? 32'h00000000
                       : hit_low    ? rd_low
                       : hit_latch  ? rd_latch
                       : hit_state  ? rd_state
                       : 32'h00000000;
   assign pslverr_next = apb_setup ? bad_access : pslverr_reg;

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_reg      <= `PCS_PC_RESET;
         latch_reg   <= `PCS_LATCH_RESET;
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else begin
         pc_reg      <= pc_next;
         latch_reg   <= latch_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ****************************************
   // Return stack
   // ****************************************
   pc_return_stack #(
      .WIDTH (`PCS_PC_WIDTH),
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (do_push),
      .pop       (do_pop),
      .push_data (push_value),
      .pop_data  (pop_value),
      .fill_ptr  (stack_fill)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata     = prdata_reg;
   assign pready     = 1'b1;
   assign pslverr    = pslverr_reg && apb_access;
   assign pc_value   = pc_reg;
   // Single page: latch page bits cannot reach the fetch address
   assign fetch_addr = pc_reg[`PCS_FETCH_MSB:0];

   // ****************************************
   // Checks
   // ****************************************
   a_reset_clears_pc: assert property (@(posedge pclk)
      $rose(presetn) |-> pc_reg == 13'h0000)
      else $error("program counter not zero after reset");

   a_step_advance: assert property (@(posedge pclk) disable iff (!presetn)
      (pc_src == pc_stack_pkg::SRC_STEP) |=> pc_reg == $past(pc_reg) + 13'h0001)
      else $error("program counter did not advance by one");

   a_low_write_load: assert property (@(posedge pclk) disable iff (!presetn)
      (pc_src == pc_stack_pkg::SRC_LOW_WRITE)
      |=> pc_reg == {$past(latch_reg), $past(pwdata[7:0])})
      else $error("low byte write did not load upper bits from latch");

   a_branch_page: assert property (@(posedge pclk) disable iff (!presetn)
      (pc_src == pc_stack_pkg::SRC_BRANCH)
      |=> pc_reg[12:11] == $past(latch_reg[4:3])
          && pc_reg[10:0] == $past(branch_target))
      else $error("branch did not combine latch page and target");

   // Fetch follows the target alone, whatever the latch page bits hold
   a_fetch_page_free: assert property (@(posedge pclk) disable iff (!presetn)
      branch_any && !interrupt_take |=> fetch_addr == $past(branch_target))
      else $error("latch page bits reached the fetch address");

   a_call_resume: assert property (@(posedge pclk) disable iff (!presetn)
      branch_call && !interrupt_take |=> pop_value == $past(pc_reg) + 13'h0001)
      else $error("call did not push the following address");

   a_vector_push: assert property (@(posedge pclk) disable iff (!presetn)
      interrupt_take |=> pc_reg == VECTOR_ADDR && pop_value == $past(pc_reg))
      else $error("interrupt did not vector and save the resume address");

   a_return_pops: assert property (@(posedge pclk) disable iff (!presetn)
      do_pop |=> pc_reg == $past(pop_value))
      else $error("return did not load the stack top");

   a_latch_kept: assert property (@(posedge pclk) disable iff (!presetn)
      (do_push || do_pop) && !wr_latch |=> $stable(latch_reg))
      else $error("stack operation disturbed the latch");

   a_low_read_only: assert property (@(posedge pclk) disable iff (!presetn)
      apb_setup && !pwrite && hit_low |=> prdata[31:8] == 24'h000000)
      else $error("upper counter bits visible on read");

   a_low_read_value: assert property (@(posedge pclk) disable iff (!presetn)
      apb_setup && !pwrite && hit_low |=> prdata[7:0] == $past(pc_reg[7:0]))
      else $error("low byte read did not return the counter");

   // Pointer steps back silently, even past the oldest entry
   a_pop_retreat: assert property (@(posedge pclk) disable iff (!presetn)
      do_pop |=> stack_fill == $past(stack_fill) - 1'b1)
      else $error("stack pointer did not step back on pop");

   a_jump_no_push: assert property (@(posedge pclk) disable iff (!presetn)
      branch_jump && !branch_call && !interrupt_take |=> $stable(stack_fill))
      else $error("plain jump moved the stack pointer");

   a_hold_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (pc_src == pc_stack_pkg::SRC_HOLD) |=> $stable(pc_reg))
      else $error("program counter moved with no operation");

   a_state_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
      apb_access && pwrite && hit_state |-> pslverr)
      else $error("write to the state word was not refused");

endmodule : program_counter_and_stack

// ---- core_sequencer_model.sv ----
// Decoder and interrupt side model: turns a command code into control pulses
`timescale 1ns/1ns

module core_sequencer_model (
   input  wire logic [2:0]  op_code,
   output logic             step,
   output logic             branch_jump,
   output logic             branch_call,
   output logic             return_plain,
   output logic             return_with_literal,
   output logic             interrupt_exit,
   output logic             interrupt_take
);
   // ****************************************
   // Command decode
   // ****************************************
   // One code per cycle, so two operations never collide
   assign step                = (op_code == 3'h1);
   assign branch_jump         = (op_code == 3'h2);
   assign branch_call         = (op_code == 3'h3);
   assign return_plain        = (op_code == 3'h4);
   assign return_with_literal = (op_code == 3'h5);
   assign interrupt_exit      = (op_code == 3'h6);
   assign interrupt_take      = (op_code == 3'h7);
endmodule : core_sequencer_model

// ---- program_counter_and_stack_test.sv ----
// Self-checking bench for the program counter and return stack
`timescale 1ns/1ns

module program_counter_and_stack_test;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  op_code;
   logic [10:0] branch_target;
   logic        step, branch_jump, branch_call, return_plain;
   logic        return_with_literal, interrupt_exit, interrupt_take;
   logic [12:0] pc_value;
   logic [10:0] fetch_addr;
   logic [31:0] rd;
   logic        err;
   int          miscompares;
   int          checked;

   core_sequencer_model model (
      .op_code(op_code), .step(step), .branch_jump(branch_jump),
      .branch_call(branch_call), .return_plain(return_plain),
      .return_with_literal(return_with_literal), .interrupt_exit(interrupt_exit),
      .interrupt_take(interrupt_take));

   program_counter_and_stack uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .step(step), .branch_call(branch_call),
      .branch_jump(branch_jump), .branch_target(branch_target),
      .return_plain(return_plain), .return_with_literal(return_with_literal),
      .interrupt_exit(interrupt_exit), .interrupt_take(interrupt_take),
      .pc_value(pc_value), .fetch_addr(fetch_addr));

   always #4 pclk = ~pclk;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run;
      if (miscompares == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Entered and left just after a rising edge; one idle cycle follows each transfer
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The wait ends at the first edge that sees pready high; pready is tied high, so that is the access edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Code stays applied until the next call, so operations can run back to back
   task automatic op(input logic [2:0] c, input logic [10:0] t);
      op_code <= c;
      branch_target <= t;
      @(posedge pclk);
   endtask : op

   task automatic pc_is(input logic [12:0] exp);
      @(negedge pclk);
      chk("pc_value", {19'h0, exp}, {19'h0, pc_value});
      @(posedge pclk);
   endtask : pc_is

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      op_code = 3'h0;
      branch_target = 11'h000;
      miscompares = 0;
      checked = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      pc_is(13'h0000);
      chk("fetch_addr", 32'h0, {21'h0, fetch_addr});
      apb(1'b0, 12'h000, 32'h0);
      chk("low byte", 32'h0, rd);
      apb(1'b1, 12'h004, 32'hffffffff);
      apb(1'b0, 12'h004, 32'h0);
      chk("latch", 32'h1f, rd);
      // Low byte write carries all five latch bits into the top
      apb(1'b1, 12'h000, 32'h00000123);
      pc_is(13'h1f23);
      chk("fetch_addr", 32'h723, {21'h0, fetch_addr});
      apb(1'b0, 12'h000, 32'h0);
      chk("low byte", 32'h23, rd);
      op(3'h2, 11'h456);
      op(3'h0, 11'h000);
      pc_is(13'h1c56);
      op(3'h1, 11'h000);
      op(3'h0, 11'h000);
      pc_is(13'h1c57);
      op(3'h3, 11'h010);
      op(3'h0, 11'h000);
      pc_is(13'h1810);
      op(3'h4, 11'h000);
      op(3'h0, 11'h000);
      pc_is(13'h1c58);
      apb(1'b0, 12'h004, 32'h0);
      chk("latch", 32'h1f, rd);
      op(3'h7, 11'h000);
      op(3'h0, 11'h000);
      pc_is(13'h0004);
      op(3'h6, 11'h000);
      op(3'h0, 11'h000);
      pc_is(13'h1c58);
      // Nine calls in a row: the ninth lands on the slot of the first
      apb(1'b1, 12'h004, 32'h0);
      for (int k = 1; k <= 9; k++) op(3'h3, 11'(k * 16));
      op(3'h0, 11'h000);
      for (int j = 1; j <= 9; j++) begin
         op(3'(4 + (j % 3)), 11'h000);
         op(3'h0, 11'h000);
         pc_is((j <= 8) ? 13'(16 * (9 - j) + 1) : 13'h0081);
      end
      // Reset in mid-run clears a non-zero counter
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      pc_is(13'h0000);
      // Stack state stays hidden and no overrun is flagged
      apb(1'b0, 12'h008, 32'h0);
      chk("state word", 32'h0, rd);
      chk("state error", 32'h0, {31'h0, err});
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, 12'h008, 32'h5);
      chk("read-only error", 32'h1, {31'h0, err});
      complete_run();
   end

   initial begin
      repeat (3000) @(posedge pclk);
      miscompares++;
      complete_run();
   end
endmodule : program_counter_and_stack_test
